// *** hw/jtp_tap.sv ***
// Test access port controller with instruction, identification and bypass registers.
//
// Function
// - Mode select steers each TAP state change on every test clock.
// - Serial instructions and data shift in from the data input.
// - Data output changes only on the falling test clock edge or when a reset clears it.
// - Data output stays released unless a shift is in progress.
// - All port logic is clocked by the master clock and steps on sampled test clock edges.
// - Low test reset forces Test-Logic-Reset without any test clock edge.
`timescale 1ns/1ps
module jtp_tap
	import jtp_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic tck_pin,
	input wire logic tms_pin,
	input wire logic tms_drv,
	input wire logic tdi_pin,
	input wire logic tdi_drv,
	input wire logic trst_n_pin,
	output logic tdo,
	output logic tdo_oe,
	output jtp_state_t tap_state,
	output logic [JTP_IR_W-1:0] instr
);

	////////////////////////////////////////////////////////////////////////////////

	function automatic jtp_state_t tap_next(input jtp_state_t st, input logic tms);
		jtp_state_t n;
		n = JTP_TLR;
		unique case (st)
			JTP_TLR: n = tms ? JTP_TLR : JTP_RTI;
			JTP_RTI: n = tms ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_DR: n = tms ? JTP_SEL_IR : JTP_CAP_DR;
			JTP_CAP_DR: n = tms ? JTP_EXIT1_DR : JTP_SHIFT_DR;
			JTP_SHIFT_DR: n = tms ? JTP_EXIT1_DR : JTP_SHIFT_DR;
			JTP_EXIT1_DR: n = tms ? JTP_UPD_DR : JTP_PAUSE_DR;
			JTP_PAUSE_DR: n = tms ? JTP_EXIT2_DR : JTP_PAUSE_DR;
			JTP_EXIT2_DR: n = tms ? JTP_UPD_DR : JTP_SHIFT_DR;
			JTP_UPD_DR: n = tms ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_IR: n = tms ? JTP_TLR : JTP_CAP_IR;
			JTP_CAP_IR: n = tms ? JTP_EXIT1_IR : JTP_SHIFT_IR;
			JTP_SHIFT_IR: n = tms ? JTP_EXIT1_IR : JTP_SHIFT_IR;
			JTP_EXIT1_IR: n = tms ? JTP_UPD_IR : JTP_PAUSE_IR;
			JTP_PAUSE_IR: n = tms ? JTP_EXIT2_IR : JTP_PAUSE_IR;
			JTP_EXIT2_IR: n = tms ? JTP_UPD_IR : JTP_SHIFT_IR;
			JTP_UPD_IR: n = tms ? JTP_SEL_DR : JTP_RTI;
			default: n = JTP_TLR;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	jtp_pins_t pins_raw;
	jtp_pins_t pins_s;
	logic tck_d_r;
	logic tck_d_nxt;
	logic tck_rise;
	logic tck_fall;

	// Pull-ups are modelled here: an undriven line reads as high.
	always_comb begin
		pins_raw.tck = tck_pin;
		pins_raw.tms = tms_drv ? tms_pin : 1'b1;
		pins_raw.tdi = tdi_drv ? tdi_pin : 1'b1;
		pins_raw.trst_n = trst_n_pin;
	end

	jtp_sync u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.d(pins_raw),
		.q(pins_s)
	);

	// The test clock is only sampled, so it must stay well below half the core rate.
	always_comb begin
		tck_d_nxt = srst ? 1'b0 : pins_s.tck;
		tck_rise = pins_s.tck & ~tck_d_r;
		tck_fall = ~pins_s.tck & tck_d_r;
	end

	always_ff @(posedge core_clk) begin
		tck_d_r <= tck_d_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////

	jtp_state_t st_r;
	jtp_state_t st_nxt;
	logic [JTP_IR_W-1:0] ir_r;
	logic [JTP_IR_W-1:0] ir_nxt;
	logic [JTP_IR_W-1:0] ir_sh_r;
	logic [JTP_IR_W-1:0] ir_sh_nxt;
	logic [JTP_DR_W-1:0] dr_sh_r;
	logic [JTP_DR_W-1:0] dr_sh_nxt;
	logic byp_r;
	logic byp_nxt;
	logic tdo_r;
	logic tdo_nxt;
	logic tdo_oe_r;
	logic tdo_oe_nxt;
	logic shifting;

	always_comb begin
		st_nxt = st_r;
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		dr_sh_nxt = dr_sh_r;
		byp_nxt = byp_r;
		tdo_nxt = tdo_r;
		tdo_oe_nxt = tdo_oe_r;
		shifting = (st_r == JTP_SHIFT_DR) || (st_r == JTP_SHIFT_IR);
		if (tck_rise) begin
			st_nxt = tap_next(st_r, pins_s.tms);
			unique case (st_r)
				JTP_TLR: ir_nxt = JTP_IR_IDCODE;
				JTP_CAP_IR: ir_sh_nxt = JTP_IR_CAPTURE;
				JTP_SHIFT_IR: ir_sh_nxt = {pins_s.tdi, ir_sh_r[JTP_IR_W-1:1]};
				JTP_UPD_IR: ir_nxt = ir_sh_r;
				JTP_CAP_DR: begin
					dr_sh_nxt = JTP_ID_VALUE;
					byp_nxt = 1'b0;
				end
				JTP_SHIFT_DR: begin
					if (ir_r == JTP_IR_IDCODE) begin
						dr_sh_nxt = {pins_s.tdi, dr_sh_r[JTP_DR_W-1:1]};
					end else begin
						byp_nxt = pins_s.tdi;
					end
				end
				default: ir_nxt = ir_r;
			endcase
		end
		// Output bit and its enable move only on the falling edge or when a reset clears them.
		if (tck_fall) begin
			tdo_oe_nxt = shifting;
			if (st_r == JTP_SHIFT_IR) begin
				tdo_nxt = ir_sh_r[0];
			end else if (st_r == JTP_SHIFT_DR) begin
				tdo_nxt = (ir_r == JTP_IR_IDCODE) ? dr_sh_r[0] : byp_r;
			end
		end
		// Test reset acts at once; it does not wait for a test clock edge.
		if (!pins_s.trst_n || srst) begin
			st_nxt = JTP_TLR;
			ir_nxt = JTP_IR_IDCODE;
			ir_sh_nxt = '0;
			dr_sh_nxt = '0;
			byp_nxt = 1'b0;
			tdo_nxt = 1'b0;
			tdo_oe_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		st_r <= st_nxt;
		ir_r <= ir_nxt;
		ir_sh_r <= ir_sh_nxt;
		dr_sh_r <= dr_sh_nxt;
		byp_r <= byp_nxt;
		tdo_r <= tdo_nxt;
		tdo_oe_r <= tdo_oe_nxt;
	end

	assign tdo = tdo_r;
	assign tdo_oe = tdo_oe_r;
	assign tap_state = st_r;
	assign instr = ir_r;

	////////////////////////////////////////////////////////////////////////////////

	logic [2:0] tms_hi_cnt_r;
	logic [2:0] tms_hi_cnt_nxt;

	always_comb begin
		tms_hi_cnt_nxt = tms_hi_cnt_r;
		if (srst || !pins_s.trst_n) begin
			tms_hi_cnt_nxt = '0;
		end else if (tck_rise) begin
			if (!pins_s.tms) begin
				tms_hi_cnt_nxt = '0;
			end else if (tms_hi_cnt_r != JTP_TLR_TMS_CNT) begin
				tms_hi_cnt_nxt = tms_hi_cnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		tms_hi_cnt_r <= tms_hi_cnt_nxt;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	AST_TRST_FORCE: assert property (!pins_s.trst_n |=> st_r == JTP_TLR)
		else $error("test reset did not force Test-Logic-Reset");
	AST_TMS_FIVE: assert property (tms_hi_cnt_r == JTP_TLR_TMS_CNT |-> st_r == JTP_TLR)
		else $error("five high mode selects did not reach Test-Logic-Reset");
	AST_STEP: assert property (tck_rise && pins_s.trst_n |=>
			st_r == tap_next($past(st_r), $past(pins_s.tms)))
		else $error("TAP state did not follow mode select");
	AST_HOLD: assert property (!tck_rise && pins_s.trst_n |=> $stable(st_r))
		else $error("TAP state moved without a test clock rise");
	AST_TDO_FALL: assert property ($changed(tdo_r) && pins_s.trst_n |-> $past(tck_fall))
		else $error("data output changed off the falling edge");
	AST_TDO_OFF: assert property (tck_fall && !shifting |=> !tdo_oe_r)
		else $error("data output driven outside a shift");
	AST_PULL_TMS: assert property (!tms_drv ##1 !tms_drv |=> pins_s.tms)
		else $error("undriven mode select not seen high");
	AST_PULL_TDI: assert property (!tdi_drv ##1 !tdi_drv |=> pins_s.tdi)
		else $error("undriven data input not seen high");
	AST_SHIFT_IN: assert property (tck_rise && pins_s.trst_n && st_r == JTP_SHIFT_DR
			&& ir_r == JTP_IR_IDCODE |=> dr_sh_r[JTP_DR_W-1] == $past(pins_s.tdi))
		else $error("data bit not shifted in");
	AST_IR_UPD: assert property (tck_rise && pins_s.trst_n && st_r == JTP_UPD_IR
			|=> ir_r == $past(ir_sh_r))
		else $error("instruction not updated");

endmodule

// *** hw/jtp_pkg.sv ***
// Package with the test access port types and constants.
package jtp_pkg;

	localparam int JTP_IR_W = 4;
	localparam int JTP_DR_W = 32;
	localparam logic [3:0] JTP_IR_IDCODE = 4'h1;
	localparam logic [3:0] JTP_IR_BYPASS = 4'hf;
	localparam logic [3:0] JTP_IR_CAPTURE = 4'h1;
	// Identification value is arbitrary.
	localparam logic [31:0] JTP_ID_VALUE = 32'h0000_0001;
	localparam logic [2:0] JTP_TLR_TMS_CNT = 3'h5;

	typedef enum logic [15:0] {
		JTP_TLR = 16'h0001,
		JTP_RTI = 16'h0002,
		JTP_SEL_DR = 16'h0004,
		JTP_CAP_DR = 16'h0008,
		JTP_SHIFT_DR = 16'h0010,
		JTP_EXIT1_DR = 16'h0020,
		JTP_PAUSE_DR = 16'h0040,
		JTP_EXIT2_DR = 16'h0080,
		JTP_UPD_DR = 16'h0100,
		JTP_SEL_IR = 16'h0200,
		JTP_CAP_IR = 16'h0400,
		JTP_SHIFT_IR = 16'h0800,
		JTP_EXIT1_IR = 16'h1000,
		JTP_PAUSE_IR = 16'h2000,
		JTP_EXIT2_IR = 16'h4000,
		JTP_UPD_IR = 16'h8000
	} jtp_state_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jtp_pins_t;

endpackage

// *** hw/jtp_sync.sv ***
// Two flip-flop synchroniser for the test pins.
`timescale 1ns/1ps
module jtp_sync
	import jtp_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire jtp_pins_t d,
	output jtp_pins_t q
);

	jtp_pins_t meta_r;
	jtp_pins_t meta_nxt;
	jtp_pins_t q_r;
	jtp_pins_t q_nxt;

	// Reset value is the idle pin level: clock low, pulled-up lines high.
	always_comb begin
		meta_nxt = d;
		q_nxt = meta_r;
		if (srst) begin
			meta_nxt = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
			q_nxt = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
		end
	end

	always_ff @(posedge core_clk) begin
		meta_r <= meta_nxt;
		q_r <= q_nxt;
	end

	assign q = q_r;

endmodule

// *** verification/jtp_ctl_model.sv ***
// Behavioural test controller that drives the test pins.
`timescale 1ns/1ps
module jtp_ctl_model (
	output logic tck,
	output logic tms,
	output logic tms_drv,
	output logic tdi,
	output logic tdi_drv,
	output logic trst_n
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tms_drv = 1'b1;
		tdi = 1'b1;
		tdi_drv = 1'b1;
		trst_n = 1'b1;
	end
	////////////////////////////////////////
	// Levels settle before the rise and hold past it; the clock rests between calls.
	task automatic step(input logic m, input logic d, input logic md, input logic dd);
		tms_drv = md;
		tdi_drv = dd;
		tms = md ? m : ~tms;
		tdi = dd ? d : ~tdi;
		#8 tck = 1'b1;
		#32 tck = 1'b0;
		#24;
	endtask
	// Low pulse with the test clock held still.
	task automatic pulse_reset();
		trst_n = 1'b0;
		#40 trst_n = 1'b1;
		#20;
	endtask
endmodule

// *** verification/jtag_test_access_port_tb_top.sv ***
// Self-checking bench for the test access port against a behavioural model.
`timescale 1ns/1ps
module jtag_test_access_port_tb_top;
	import jtp_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic tck, tms, tms_drv, tdi, tdi_drv, trst_n, tdo, tdo_oe;
	jtp_state_t tap_state;
	jtp_state_t ms;
	logic [JTP_IR_W-1:0] instr;
	logic [3:0] mi;
	logic [31:0] sh;
	int w;
	int mismatches = 0;
	int n_tests = 0;
	always #2.5 core_clk = ~core_clk;
	jtp_ctl_model ctl (.tck, .tms, .tms_drv, .tdi, .tdi_drv, .trst_n);
	jtp_tap uut (.core_clk, .srst, .tck_pin(tck), .tms_pin(tms), .tms_drv, .tdi_pin(tdi),
		.tdi_drv, .trst_n_pin(trst_n), .tdo, .tdo_oe, .tap_state, .instr);
	////////////////////////////////////////
	function automatic jtp_state_t nx(jtp_state_t s, logic m);
		case (s)
			JTP_TLR: return m ? JTP_TLR : JTP_RTI;
			JTP_RTI, JTP_UPD_DR, JTP_UPD_IR: return m ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_DR: return m ? JTP_SEL_IR : JTP_CAP_DR;
			JTP_CAP_DR, JTP_SHIFT_DR: return m ? JTP_EXIT1_DR : JTP_SHIFT_DR;
			JTP_EXIT1_DR, JTP_EXIT2_DR: return m ? JTP_UPD_DR : (s == JTP_EXIT2_DR ? JTP_SHIFT_DR : JTP_PAUSE_DR);
			JTP_PAUSE_DR: return m ? JTP_EXIT2_DR : JTP_PAUSE_DR;
			JTP_SEL_IR: return m ? JTP_TLR : JTP_CAP_IR;
			JTP_CAP_IR, JTP_SHIFT_IR: return m ? JTP_EXIT1_IR : JTP_SHIFT_IR;
			JTP_EXIT1_IR, JTP_EXIT2_IR: return m ? JTP_UPD_IR : (s == JTP_EXIT2_IR ? JTP_SHIFT_IR : JTP_PAUSE_IR);
			default: return m ? JTP_EXIT2_IR : JTP_PAUSE_IR;
		endcase
	endfunction
	task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Undriven inputs count as high in the model, as the pull-ups make them.
	task automatic go(logic m, logic d, logic md, logic dd);
		logic em;
		logic ed;
		logic sft;
		em = md ? m : 1'b1;
		ed = dd ? d : 1'b1;
		ctl.step(m, d, md, dd);
		if (ms == JTP_CAP_IR) sh = 32'h1;
		if (ms == JTP_CAP_DR) sh = (mi == JTP_IR_IDCODE) ? JTP_ID_VALUE : 32'h0;
		w = (ms == JTP_SHIFT_IR) ? JTP_IR_W : (mi == JTP_IR_IDCODE) ? JTP_DR_W : 1;
		if (ms == JTP_SHIFT_IR || ms == JTP_SHIFT_DR) sh = (sh >> 1) | (32'(ed) << (w - 1));
		if (ms == JTP_UPD_IR) mi = sh[3:0];
		ms = nx(ms, em);
		if (ms == JTP_TLR) mi = JTP_IR_IDCODE;
		sft = (ms == JTP_SHIFT_IR || ms == JTP_SHIFT_DR);
		chk("tap_state", 32'(ms), 32'(tap_state));
		chk("tdo_oe", 32'(sft), 32'(tdo_oe));
		if (sft) chk("tdo", 32'(sh[0]), 32'(tdo));
		if (ms == JTP_RTI) chk("instr", 32'(mi), 32'(instr));
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		ms = JTP_TLR;
		mi = JTP_IR_IDCODE;
		sh = 32'h0;
		w = 1;
		void'($urandom(36));
		repeat (4) @(negedge core_clk);
		srst = 1'b0;
		ctl.pulse_reset();
		chk("reset state", 32'(JTP_TLR), 32'(tap_state));
		chk("reset oe", 32'h0, 32'(tdo_oe));
		$display("reset test done");
		go(0, 0, 1, 1);
		go(1, 0, 1, 1);
		go(0, 0, 1, 1);
		for (int i = 0; i < 34; i++) go(i == 33, 1'($urandom), 1, 1);
		$display("identification test done");
		for (int i = 0; i < 400; i++) go(1'($urandom), 1'($urandom), |3'($urandom), |3'($urandom));
		$display("random walk done");
		for (int i = 0; i < 5; i++) go(1, 1'($urandom), 1, 1);
		chk("five high", 32'(JTP_TLR), 32'(tap_state));
		$display("five high test done");
		// Load the bypass instruction, then pass random bits through the one-bit path.
		go(0, 0, 1, 1);
		go(1, 0, 1, 1);
		go(1, 0, 1, 1);
		go(0, 0, 1, 1);
		go(0, 0, 1, 1);
		for (int i = 0; i < JTP_IR_W; i++) go(i == JTP_IR_W - 1, JTP_IR_BYPASS[i], 1, 1);
		go(1, 0, 1, 1);
		go(0, 0, 1, 1);
		chk("bypass instr", 32'(JTP_IR_BYPASS), 32'(instr));
		go(1, 0, 1, 1);
		go(0, 0, 1, 1);
		for (int i = 0; i < 9; i++) go(i == 8, 1'($urandom), 1, 1);
		$display("bypass test done");
		go(0, 0, 1, 1);
		go(1, 0, 1, 1);
		go(0, 0, 1, 1);
		go(0, 0, 1, 1);
		ctl.pulse_reset();
		ms = JTP_TLR;
		mi = JTP_IR_IDCODE;
		chk("test reset", 32'(JTP_TLR), 32'(tap_state));
		chk("test reset oe", 32'h0, 32'(tdo_oe));
		$display("test reset done");
		give_verdict();
	end
	initial begin
		#60000;
		mismatches++;
		give_verdict();
	end
endmodule
